// >>> port_ab_pkg.sv
// Constants, field layouts and carrier types for the port A/B pin control block.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses and a 10 MHz aclk.
// Functional notes
// - Except expanded mode 2: port A pins plain I/O
// - Expanded mode 2, strobe clear: outputs drive address
// - Port A pins 2-0 always feed key, capture
// - Port A pull-ups set per bit by software
// - Bus-drive select forces pins 7-4 pull-ups off
// - Pull-up needs input, data 1; off in standby
// - Port B is 8-bit I/O or data bus
// - Port B direction write-only, zero; reads port 7
// - Expanded, narrow bus: port B is data bus
// - Wide bus or unexpanded: port B follows direction bits
// - Port B output value drives pins, resets 0
// - Port B output value always readable and writable
// - Port B levels readable; writes update port8 direction
package port_ab_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int PA_LOW_W = 3;

  // Register byte addresses
  localparam logic [11:0] OFF_PORT_B_DIRECTION    = 12'h000;
  localparam logic [11:0] OFF_PORT_B_OUTPUT_VALUE = 12'h004;
  localparam logic [11:0] OFF_PORT_B_PIN_LEVELS   = 12'h008;
  localparam logic [11:0] OFF_PORT_A_DIRECTION    = 12'h00C;
  localparam logic [11:0] OFF_PORT_A_OUTPUT_VALUE = 12'h010;
  localparam logic [11:0] OFF_SYSTEM_CONTROL      = 12'h014;
  localparam logic [11:0] OFF_PULLUP_STATUS       = 12'h018;
  localparam logic [11:0] OFF_PORT_A_PIN_LEVELS   = 12'h01C;

  // System control field positions
  localparam int SC_MODE_LSB   = 0;
  localparam int SC_EXPAND_BIT = 2;
  localparam int SC_STROBE_BIT = 3;
  localparam int SC_BDS_BIT    = 4;
  localparam int SC_WIDTH_BIT  = 5;

  // Reset values
  localparam logic [7:0] PORT_RESET     = 8'h00;
  localparam logic [1:0] MODE_RESET     = 2'h2;
  localparam logic       CTRL_BIT_RESET = 1'b0;

  // Operating modes
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;

  // Pull-up groups
  localparam logic [7:0] PA_HIGH_NIBBLE = 8'hF0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       bus_width_select;
    logic       bus_drive_select;
    logic       io_strobe_select;
    logic       expansion_enable;
    logic [1:0] mode;
  } sys_ctrl_t;

  typedef struct packed {
    logic oe;
    logic out;
  } pin_drive_t;

endpackage

// >>> pin_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to aclk; only the second stage is used downstream.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// >>> port_a_b_pin_control.sv
// Port A low-pin multiplexer, port A pull-up control and port B I/O with AXI4-Lite registers.
// Assumes pins arrive asynchronously; external address and data bus signals come from aclk logic.
`timescale 1ns/1ps
module port_a_b_pin_control (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hw_standby,
  input  wire logic [2:0]  ext_addr_hi,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        ext_data_oe,
  output logic [7:0]       ext_data_in,
  input  wire logic [2:0]  pa_pin_in,
  output logic [2:0]       pa_pin_out,
  output logic [2:0]       pa_pin_oe,
  output logic [7:0]       pa_pullup_en,
  output logic [2:0]       key_wakeup_in_10,
  output logic [2:0]       capture_in_10,
  input  wire logic [7:0]  pa_high_pin_in,
  input  wire logic [7:0]  pb_pin_in,
  output logic [7:0]       pb_pin_out,
  output logic [7:0]       pb_pin_oe,
  input  wire logic [7:0]  port7_pin_in,
  output logic [7:0]       port8_direction
);

  // Pin drive: alternate function wins when selected, else direction bit picks output
  function automatic port_ab_pkg::pin_drive_t pin_drive(
    input logic dir,
    input logic port_val,
    input logic alt_sel,
    input logic alt_oe,
    input logic alt_val
  );
    port_ab_pkg::pin_drive_t d;
    d.oe  = alt_sel ? alt_oe : dir;
    d.out = alt_sel ? alt_val : port_val;
    return d;
  endfunction
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    return addr[11:2] == off[11:2];
  endfunction

  logic [2:0] pa_low_sync;
  logic [7:0] pa_high_sync;
  logic [7:0] pb_sync;
  logic [7:0] port7_sync;
  logic       standby_sync;

  pin_sync #(.WIDTH(3)) u_sync_pa_low (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pa_pin_in),
    .sync_out (pa_low_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_pa_high (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pa_high_pin_in),
    .sync_out (pa_high_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_pb (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pb_pin_in),
    .sync_out (pb_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_p7 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (port7_pin_in),
    .sync_out (port7_sync)
  );
  pin_sync #(.WIDTH(1)) u_sync_standby (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (hw_standby),
    .sync_out (standby_sync)
  );

  logic [7:0]             port_b_direction_reg;
  logic [7:0]             port_b_output_value_reg;
  logic [7:0]             port_a_direction_reg;
  logic [7:0]             port_a_output_value_reg;
  port_ab_pkg::sys_ctrl_t system_control_reg;
  // Write channel holding state
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  logic        wr_lane0;
  logic        wr_mapped;
  assign do_write  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_lane0  = do_write && wstrb_reg[0];
  assign wr_mapped = addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_B_DIRECTION)
                  || addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_B_OUTPUT_VALUE)
                  || addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_B_PIN_LEVELS)
                  || addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_A_DIRECTION)
                  || addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_A_OUTPUT_VALUE)
                  || addr_hit(awaddr_reg, port_ab_pkg::OFF_SYSTEM_CONTROL)
                  || addr_hit(awaddr_reg, port_ab_pkg::OFF_PULLUP_STATUS)
                  || addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_A_PIN_LEVELS);

  // Address and data are taken in either order and held until the response is sent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !do_write;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= port_ab_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? port_ab_pkg::RESP_OKAY : port_ab_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Port B direction is write-only; its address reads port 7 instead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_direction_reg <= port_ab_pkg::PORT_RESET;
    end else if (wr_lane0 && addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_B_DIRECTION)) begin
      port_b_direction_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_output_value_reg <= port_ab_pkg::PORT_RESET;
    end else if (wr_lane0 && addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_B_OUTPUT_VALUE)) begin
      port_b_output_value_reg <= wdata_reg[7:0];
    end
  end

  // Shared address: pin levels on read, port 8 direction on write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port8_direction <= port_ab_pkg::PORT_RESET;
    end else if (wr_lane0 && addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_B_PIN_LEVELS)) begin
      port8_direction <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_direction_reg <= port_ab_pkg::PORT_RESET;
    end else if (wr_lane0 && addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_A_DIRECTION)) begin
      port_a_direction_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_output_value_reg <= port_ab_pkg::PORT_RESET;
    end else if (wr_lane0 && addr_hit(awaddr_reg, port_ab_pkg::OFF_PORT_A_OUTPUT_VALUE)) begin
      port_a_output_value_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_control_reg.mode             <= port_ab_pkg::MODE_RESET;
      system_control_reg.expansion_enable <= port_ab_pkg::CTRL_BIT_RESET;
      system_control_reg.io_strobe_select <= port_ab_pkg::CTRL_BIT_RESET;
      system_control_reg.bus_drive_select <= port_ab_pkg::CTRL_BIT_RESET;
      system_control_reg.bus_width_select <= port_ab_pkg::CTRL_BIT_RESET;
    end else if (wr_lane0 && addr_hit(awaddr_reg, port_ab_pkg::OFF_SYSTEM_CONTROL)) begin
      system_control_reg.mode             <= wdata_reg[port_ab_pkg::SC_MODE_LSB +: 2];
      system_control_reg.expansion_enable <= wdata_reg[port_ab_pkg::SC_EXPAND_BIT];
      system_control_reg.io_strobe_select <= wdata_reg[port_ab_pkg::SC_STROBE_BIT];
      system_control_reg.bus_drive_select <= wdata_reg[port_ab_pkg::SC_BDS_BIT];
      system_control_reg.bus_width_select <= wdata_reg[port_ab_pkg::SC_WIDTH_BIT];
    end
  end

  // Mode decode
  logic mode2_expanded;
  logic pb_expanded;
  logic pb_data_bus;
  assign mode2_expanded = (system_control_reg.mode == port_ab_pkg::MODE_2)
                       && system_control_reg.expansion_enable;
  // Mode 1 is always expanded; modes 2 and 3 follow the expansion bit
  assign pb_expanded = (system_control_reg.mode == port_ab_pkg::MODE_1)
                    || (((system_control_reg.mode == port_ab_pkg::MODE_2)
                      || (system_control_reg.mode == port_ab_pkg::MODE_3))
                      && system_control_reg.expansion_enable);
  assign pb_data_bus = pb_expanded && !system_control_reg.bus_width_select;
  // Pin drive next values; registered so every pin output comes from a flop
  logic [2:0] pa_oe_next;
  logic [2:0] pa_out_next;
  logic [7:0] pb_oe_next;
  logic [7:0] pb_out_next;
  logic [7:0] pa_pullup_next;
  always_comb begin
    port_ab_pkg::pin_drive_t d;
    d = '0;
    for (int i = 0; i < port_ab_pkg::PA_LOW_W; i++) begin
      // Address only replaces port data in expanded mode 2 with strobe select clear
      d = pin_drive(port_a_direction_reg[i], port_a_output_value_reg[i],
                    mode2_expanded && !system_control_reg.io_strobe_select,
                    port_a_direction_reg[i], ext_addr_hi[i]);
      pa_oe_next[i]  = d.oe;
      pa_out_next[i] = d.out;
    end
  end

  always_comb begin
    port_ab_pkg::pin_drive_t d;
    d = '0;
    for (int i = 0; i < port_ab_pkg::PORT_W; i++) begin
      d = pin_drive(port_b_direction_reg[i], port_b_output_value_reg[i],
                    pb_data_bus, ext_data_oe, ext_data_out[i]);
      pb_oe_next[i]  = d.oe;
      pb_out_next[i] = d.out;
    end
  end

  // Pull-up only on an input pin whose output value is 1; off in hardware standby
  always_comb begin
    pa_pullup_next = ~port_a_direction_reg & port_a_output_value_reg;
    if (system_control_reg.bus_drive_select) begin
      pa_pullup_next = pa_pullup_next & ~port_ab_pkg::PA_HIGH_NIBBLE;
    end
    if (standby_sync) begin
      pa_pullup_next = port_ab_pkg::PORT_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_pin_oe  <= 3'h0;
      pa_pin_out <= 3'h0;
      pb_pin_oe  <= port_ab_pkg::PORT_RESET;
      pb_pin_out <= port_ab_pkg::PORT_RESET;
    end else begin
      pa_pin_oe  <= pa_oe_next;
      pa_pin_out <= pa_out_next;
      pb_pin_oe  <= pb_oe_next;
      pb_pin_out <= pb_out_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_pullup_en <= port_ab_pkg::PORT_RESET;
    end else begin
      pa_pullup_en <= pa_pullup_next;
    end
  end

  // Key and capture inputs see the pin level whatever the pin is doing
  assign key_wakeup_in_10 = pa_low_sync;
  assign capture_in_10    = pa_low_sync;
  // Data bus input path: registered pin levels of port B
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_data_in <= port_ab_pkg::PORT_RESET;
    end else begin
      ext_data_in <= pb_sync;
    end
  end

  // Read channel: one read at a time, answered one cycle after the address is taken
  logic [31:0] rdata_next;
  logic [1:0]  rresp_next;
  always_comb begin
    rdata_next = 32'h00000000;
    rresp_next = port_ab_pkg::RESP_OKAY;
    if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_PORT_B_DIRECTION)) begin
      rdata_next[7:0] = port7_sync;
    end else if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_PORT_B_OUTPUT_VALUE)) begin
      rdata_next[7:0] = port_b_output_value_reg;
    end else if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_PORT_B_PIN_LEVELS)) begin
      rdata_next[7:0] = pb_sync;
    end else if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_PORT_A_DIRECTION)) begin
      rdata_next[7:0] = port_a_direction_reg;
    end else if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_PORT_A_OUTPUT_VALUE)) begin
      rdata_next[7:0] = port_a_output_value_reg;
    end else if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_SYSTEM_CONTROL)) begin
      rdata_next[5:0] = system_control_reg;
    end else if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_PULLUP_STATUS)) begin
      rdata_next[7:0] = pa_pullup_en;
    end else if (addr_hit(s_axi_araddr, port_ab_pkg::OFF_PORT_A_PIN_LEVELS)) begin
      rdata_next[7:0] = {pa_high_sync[7:3], pa_low_sync};
    end else begin
      rresp_next = port_ab_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= port_ab_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rresp_next;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> port_ab_chk.sv
// Checker for the port A/B pin control block, bound to its ports.
// Assumes a write commits one edge after both AXI halves are taken.
`timescale 1ns/1ps
module port_ab_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        hw_standby,
  input wire logic [2:0]  ext_addr_hi,
  input wire logic [7:0]  ext_data_out,
  input wire logic        ext_data_oe,
  input wire logic [2:0]  pa_pin_in,
  input wire logic [2:0]  pa_pin_out,
  input wire logic [2:0]  pa_pin_oe,
  input wire logic [7:0]  pa_pullup_en,
  input wire logic [2:0]  key_wakeup_in_10,
  input wire logic [2:0]  capture_in_10,
  input wire logic [7:0]  pb_pin_out,
  input wire logic [7:0]  pb_pin_oe
);
  logic        aw_h, w_h, s_q, amode, bus_m;
  logic [11:0] a_q;
  logic [7:0]  d_q, pbd, pbo, pad, pao, pu_exp;
  logic [5:0]  sc;
  logic [1:0]  rc;
  // Shadows of the registers: drive can only be judged against what software committed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      rc <= 2'h0;
    end else begin
      if (rc != 2'h3) rc <= rc + 2'h1;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h <= 1'b1;
        a_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h <= 1'b1;
        d_q <= s_axi_wdata[7:0];
        s_q <= s_axi_wstrb[0];
      end
      if (aw_h && w_h) begin
        aw_h <= 1'b0;
        w_h <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pbd, pbo, pad, pao} <= 32'h0;
      sc <= 6'h02;
    end else if (aw_h && w_h && s_q) begin
      case (a_q)
        12'h000: pbd <= d_q;
        12'h004: pbo <= d_q;
        12'h00C: pad <= d_q;
        12'h010: pao <= d_q;
        12'h014: sc <= d_q[5:0];
        default: ;
      endcase
    end
  end
  always_comb begin
    amode = sc[1:0] == 2'h2 && sc[2] && !sc[3];
    bus_m = (sc[1:0] == 2'h1 || (sc[1] && sc[2])) && !sc[5];
    pu_exp = ~pad & pao & (sc[4] ? 8'h0F : 8'hFF);
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  pa_dir_oe_a: assert property (rc == 2'h3 |-> pa_pin_oe == $past(pad[2:0]))
    else $error("port A enable wrong");
  pa_addr_a: assert property (rc == 2'h3 && $past(amode) |->
    (pa_pin_out & pa_pin_oe) == ($past(ext_addr_hi) & pa_pin_oe)) else $error("address pin wrong");
  pa_port_a: assert property (rc == 2'h3 && !$past(amode) |->
    (pa_pin_out & pa_pin_oe) == ($past(pao[2:0]) & pa_pin_oe)) else $error("port A value wrong");
  key_sync_a: assert property (rc == 2'h3 |->
    key_wakeup_in_10 == $past(pa_pin_in, 2) && capture_in_10 == key_wakeup_in_10) else $error("key input wrong");
  pull_up_a: assert property (rc == 2'h3 && (!hw_standby) [*4] |->
    pa_pullup_en == $past(pu_exp)) else $error("pull-up wrong");
  standby_off_a: assert property (hw_standby [*3] |=> pa_pullup_en == 8'h00)
    else $error("pull-up on in standby");
  pb_bus_a: assert property (rc == 2'h3 && $past(bus_m) |-> pb_pin_oe == {8{$past(ext_data_oe)}} &&
    (pb_pin_out & pb_pin_oe) == ($past(ext_data_out) & pb_pin_oe)) else $error("data bus drive wrong");
  pb_port_a: assert property (rc == 2'h3 && !$past(bus_m) |-> pb_pin_oe == $past(pbd) &&
    (pb_pin_out & pb_pin_oe) == ($past(pbo) & pb_pin_oe)) else $error("port B drive wrong");
  cover property (amode && pa_pin_oe != 3'h0);
  cover property (bus_m && ext_data_oe);
  cover property (hw_standby [*3]);
endmodule
bind port_a_b_pin_control port_ab_chk i_port_ab_chk (.*);

// >>> port_ab_pins.sv
// Pin model for port A pins 2-0 and port B, standing for the outside world.
// Assumes the bench never drives a pin that the block drives.
`timescale 1ns/1ps
module port_ab_pins (
  input  wire logic       aclk,
  input  wire logic [2:0] pa_pin_out,
  input  wire logic [2:0] pa_pin_oe,
  input  wire logic [7:0] pa_pullup_en,
  input  wire logic [2:0] pa_x,
  input  wire logic [2:0] pa_xoe,
  input  wire logic [7:0] pb_pin_out,
  input  wire logic [7:0] pb_pin_oe,
  input  wire logic [7:0] pb_x,
  input  wire logic [7:0] pb_xoe,
  output logic      [2:0] pa_pin_in,
  output logic      [7:0] pb_pin_in
);
  // An undriven line without pull-up toggles, so no lucky level can pass a check
  logic [10:0] prev = 11'h0;
  always_ff @(posedge aclk) prev <= {pa_pin_in, pb_pin_in};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pa_pin_in[i] = pa_pin_oe[i] ? pa_pin_out[i] : pa_xoe[i] ? pa_x[i] : pa_pullup_en[i] | ~prev[8 + i];
    end
    for (int i = 0; i < 8; i++) begin
      pb_pin_in[i] = pb_pin_oe[i] ? pb_pin_out[i] : pb_xoe[i] ? pb_x[i] : ~prev[i];
    end
  end
endmodule

// >>> port_a_b_pin_control_bench.sv
// Self-checking bench for the port A/B pin control block.
// Assumes the block's register map and one-edge register-to-pin latency.
`timescale 1ns/1ps
module port_a_b_pin_control_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        hw_standby, ext_data_oe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [2:0]  s_axi_awprot, s_axi_arprot, ext_addr_hi, pa_pin_in, pa_pin_out, pa_pin_oe;
  logic [2:0]  key_wakeup_in_10, capture_in_10, pa_x, pa_xoe;
  logic [7:0]  ext_data_out, ext_data_in, pa_pullup_en, pa_high_pin_in, pb_pin_in, pb_pin_out;
  logic [7:0]  pb_pin_oe, port7_pin_in, port8_direction, pb_x, pb_xoe;
  int          error_cnt, n_checks;

  port_a_b_pin_control i_port_a_b_pin_control (.*);
  port_ab_pins i_port_ab_pins (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic t_reset;
    rd(12'h004);
    chk(rd_d, 32'h0);
    rd(12'h000);
    chk(rd_d, 32'hC3);
    chk(pb_pin_oe, 8'h00);
    chk(pa_pullup_en, 8'h00);
  endtask
  task automatic t_portb;
    pb_x <= 8'h96;
    pb_xoe <= 8'h5A;
    wr(12'h000, 8'hA5);
    wr(12'h004, 8'h3C);
    tk(2);
    chk(pb_pin_oe, 8'hA5);
    chk(pb_pin_out & 8'hA5, 8'h24);
    rd(12'h004);
    chk(rd_d, 32'h3C);
    rd(12'h008);
    chk(rd_d, 32'h36);
    wr(12'h008, 8'h77);
    tk(1);
    chk(port8_direction, 8'h77);
    rd(12'h000);
    chk(rd_d, 32'hC3);
  endtask
  task automatic t_bus;
    ext_data_out <= 8'h5A;
    pb_xoe <= 8'h00;
    for (int m = 1; m < 4; m++) begin
      wr(12'h014, 8'h04 | 8'(m));
      ext_data_oe <= 1'b1;
      tk(2);
      chk(pb_pin_oe, 8'hFF);
      chk(pb_pin_out, 8'h5A);
      ext_data_oe <= 1'b0;
      tk(1);
      pb_xoe <= 8'hFF;
      pb_x <= 8'h69;
      tk(5);
      chk(ext_data_in, 8'h69);
      pb_xoe <= 8'h00;
      wr(12'h014, 8'h24 | 8'(m));
      tk(2);
      chk(pb_pin_oe, 8'hA5);
    end
  endtask
  task automatic t_pa;
    logic [7:0] scv [5] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h0E};
    logic [2:0] pe [5] = '{3'h5, 3'h5, 3'h5, 3'h1, 3'h5};
    ext_addr_hi <= 3'h3;
    pa_x <= 3'h6;
    pa_xoe <= 3'h2;
    wr(12'h00C, 8'h05);
    wr(12'h010, 8'h07);
    for (int i = 0; i < 5; i++) begin
      wr(12'h014, scv[i]);
      tk(4);
      chk(pa_pin_oe, 3'h5);
      chk(pa_pin_out & pa_pin_oe, pe[i]);
      chk(key_wakeup_in_10, pe[i] | 3'h2);
      chk(capture_in_10, pe[i] | 3'h2);
    end
  endtask
  task automatic t_pull;
    pa_xoe <= 3'h0;
    wr(12'h014, 8'h02);
    wr(12'h00C, 8'h03);
    wr(12'h010, 8'hF6);
    tk(2);
    chk(pa_pullup_en, 8'hF4);
    wr(12'h014, 8'h12);
    tk(2);
    chk(pa_pullup_en, 8'h04);
    hw_standby <= 1'b1;
    tk(4);
    chk(pa_pullup_en, 8'h00);
    hw_standby <= 1'b0;
    tk(4);
    chk(pa_pullup_en, 8'h04);
    rd(12'h018);
    chk(rd_d, 32'h04);
    rd(12'h01C);
    chk(rd_d, 32'h9E);
  endtask
  task automatic t_bad;
    wr(12'h040, 8'hFF);
    chk(wr_r, port_ab_pkg::RESP_SLVERR);
    rd(12'h040);
    chk(rd_r, port_ab_pkg::RESP_SLVERR);
    chk(rd_d, 32'h0);
    s_axi_wstrb <= 4'hE;
    wr(12'h004, 8'hFF);
    s_axi_wstrb <= 4'hF;
    chk(wr_r, port_ab_pkg::RESP_OKAY);
    rd(12'h004);
    chk(rd_d, 32'h3C);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr,
     s_axi_wdata, s_axi_awprot, s_axi_arprot, hw_standby, ext_data_oe, ext_addr_hi, ext_data_out,
     pa_x, pa_xoe, pb_x, pb_xoe} = '0;
    s_axi_wstrb = 4'hF;
    port7_pin_in = 8'hC3;
    pa_high_pin_in = 8'h9A;
    error_cnt = 0;
    n_checks = 0;
    aresetn = 1'b0;
    tk(12);
    aresetn <= 1'b1;
    t_reset();
    t_portb();
    t_bus();
    t_pa();
    t_pull();
    t_bad();
    @(posedge aclk);
    aresetn <= 1'b0;
    tk(3);
    aresetn <= 1'b1;
    t_reset();
    print_verdict();
  end
endmodule
